// >>> hdl/ccr_pkg.sv
package ccr_pkg;
  // Register index and field positions
  localparam logic [4:0] REG_COPPER_CONTROL = 5'h00;
  localparam logic [4:0] REG_FIBER_CONTROL  = 5'h01;
  localparam logic [4:0] REG_STRAP_STATUS   = 5'h02;
  localparam int BIT_SW_RESET  = 15;
  localparam int BIT_SPEED_LSB = 13;
  localparam int BIT_AUTONEG_STRAP_CONFIG_EN   = 12;
  localparam int BIT_PWR_DOWN  = 11;
  localparam int BIT_ISOLATE   = 10;
  localparam int BIT_RESTART   = 9;
  localparam int BIT_DUPLEX    = 8;
  localparam int BIT_COL_TEST  = 7;
  localparam int BIT_SPEED_MSB = 6;
  localparam logic [5:0] RSVD_RESET = 6'h00;
  // Software reset hold, in cycles
  localparam logic [3:0] SW_RESET_CYCLES = 4'h8;
  localparam logic [1:0] SPEED_1000 = 2'b10;
  localparam logic [1:0] SPEED_100  = 2'b01;
  localparam logic [1:0] SPEED_10   = 2'b00;

  typedef struct packed {
    logic       autoneg_strap_config_en;
    logic       duplex;
    logic [1:0] speed;
  } ccr_mode_t;

  typedef struct packed {
    logic       adv_1000_fd;
    logic       adv_1000_hd;
    logic       use_adv_regs;
    logic       autoneg_strap_config_run;
  } ccr_adv_t;

  typedef struct packed {
    ccr_mode_t  pend;
    ccr_mode_t  act;
    logic       pwr_down;
    logic       isolate;
    logic       col_test;
    logic [5:0] rsvd;
    logic [3:0] rst_cnt;
    logic       sw_reset;
    logic       restart;
    logic       strap_done;
    logic [15:0] rdata;
    ccr_adv_t   adv;
    logic       autoneg_strap_config_restart_pulse;
    logic       mac_off;
    logic       refclk_off;
    logic       mac_oe;
    logic       col;
    logic       tx_en_s1;
    logic       tx_en_s2;
  } ccr_state_t;

  function automatic logic strap_autoneg_strap_config(input logic [3:0] a);
    return a[3:2] == 2'b11;
  endfunction

  function automatic logic strap_duplex(input logic [3:0] a);
    return (a[3:2] == 2'b00 && a[0]) || a[3];
  endfunction

  function automatic logic strap_speed_msb(input logic [3:0] a, input logic [3:0] m);
    return a[3] || a[2] || (m[3] == 1'b0 && m[1:0] == 2'b11) || (m[1:0] == 2'b01);
  endfunction
endpackage

// >>> hdl/ccr_copper_control.sv
`timescale 1ns/1ps
module ccr_copper_control (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [4:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [15:0]               reg_rdata,
  input  wire logic [3:0]           autoneg_strap_config,
  input  wire logic [3:0]           hardware_config_strap_mode,
  input  wire logic                 keep_mac_if_on,
  input  wire logic                 refclk_pd_en,
  input  wire logic                 mac_tx_en,
  output logic                      mac_col,
  output logic                      mac_out_en,
  output logic                      mac_if_off,
  output logic                      reference_clock_output_off,
  output logic                      phy_sw_reset,
  output logic                      autoneg_strap_config_restart,
  output ccr_pkg::ccr_mode_t        oper_mode,
  output ccr_pkg::ccr_adv_t         adv_ctrl
);
  ccr_pkg::ccr_state_t s_q;
  ccr_pkg::ccr_state_t s_d;
  logic [3:0] straps_s1_q;
  logic [3:0] straps_s2_q;
  logic [3:0] mode_s1_q;
  logic [3:0] mode_s2_q;
  logic [1:0] misc_s1_q;
  logic [1:0] misc_s2_q;

  // Straps and pins pass two flops before use
  always_ff @(posedge core_clk) begin
    straps_s1_q <= autoneg_strap_config;
    straps_s2_q <= straps_s1_q;
    mode_s1_q   <= hardware_config_strap_mode;
    mode_s2_q   <= mode_s1_q;
    misc_s1_q   <= {keep_mac_if_on, refclk_pd_en};
    misc_s2_q   <= misc_s1_q;
  end

  function automatic logic [15:0] ctrl_view(input ccr_pkg::ccr_state_t s, input logic fiber);
    logic [15:0] v;
    v = 16'h0000;
    v[ccr_pkg::BIT_SW_RESET] = s.sw_reset;
    v[ccr_pkg::BIT_PWR_DOWN] = s.pwr_down;
    v[ccr_pkg::BIT_ISOLATE]  = s.isolate;
    v[ccr_pkg::BIT_COL_TEST] = s.col_test;
    if (!fiber) begin
      v[ccr_pkg::BIT_SPEED_LSB] = s.pend.speed[0];
      v[ccr_pkg::BIT_AUTONEG_STRAP_CONFIG_EN]   = s.pend.autoneg_strap_config_en;
      v[ccr_pkg::BIT_RESTART]   = s.restart;
      v[ccr_pkg::BIT_DUPLEX]    = s.pend.duplex;
      v[ccr_pkg::BIT_SPEED_MSB] = s.pend.speed[1];
      v[5:0] = s.rsvd;
    end
    return v;
  endfunction

  always_comb begin
    logic wr_cu;
    logic wr_fi;
    logic trigger;
    logic swr_set;
    logic pwr_up;
    ccr_pkg::ccr_mode_t eff;
    wr_cu   = 1'b0;
    wr_fi   = 1'b0;
    trigger = 1'b0;
    swr_set = 1'b0;
    pwr_up  = 1'b0;
    eff     = s_q.act;
    s_d = s_q;
    s_d.autoneg_strap_config_restart_pulse = 1'b0;
    s_d.tx_en_s1 = mac_tx_en;
    s_d.tx_en_s2 = s_q.tx_en_s1;
    if (reg_wr && reg_addr == ccr_pkg::REG_COPPER_CONTROL) begin
      wr_cu = 1'b1;
    end else if (reg_wr && reg_addr == ccr_pkg::REG_FIBER_CONTROL) begin
      wr_fi = 1'b1;
    end
    if (!s_q.strap_done) begin
      // Strap defaults caught once after reset release
      s_d.strap_done   = 1'b1;
      s_d.pend.autoneg_strap_config_en = ccr_pkg::strap_autoneg_strap_config(straps_s2_q);
      s_d.pend.duplex  = ccr_pkg::strap_duplex(straps_s2_q);
      s_d.pend.speed   = {ccr_pkg::strap_speed_msb(straps_s2_q, mode_s2_q), 1'b0};
      s_d.act          = s_d.pend;
      s_d.autoneg_strap_config_restart_pulse = 1'b1;
    end else begin
      if (wr_cu || wr_fi) begin
        s_d.pwr_down = reg_wdata[ccr_pkg::BIT_PWR_DOWN];
        s_d.isolate  = reg_wdata[ccr_pkg::BIT_ISOLATE];
        s_d.col_test = reg_wdata[ccr_pkg::BIT_COL_TEST];
        swr_set      = reg_wdata[ccr_pkg::BIT_SW_RESET];
        pwr_up       = s_q.pwr_down && !reg_wdata[ccr_pkg::BIT_PWR_DOWN];
      end
      if (wr_cu) begin
        s_d.pend.autoneg_strap_config_en = reg_wdata[ccr_pkg::BIT_AUTONEG_STRAP_CONFIG_EN];
        s_d.pend.duplex  = reg_wdata[ccr_pkg::BIT_DUPLEX];
        s_d.pend.speed   = {reg_wdata[ccr_pkg::BIT_SPEED_MSB], reg_wdata[ccr_pkg::BIT_SPEED_LSB]};
        s_d.rsvd         = reg_wdata[5:0];
        if (reg_wdata[ccr_pkg::BIT_RESTART]) begin
          s_d.restart = 1'b1;
        end
      end
      trigger = swr_set || pwr_up;
      if (trigger) begin
        s_d.act      = s_d.pend;
        s_d.sw_reset = 1'b1;
        s_d.rst_cnt  = ccr_pkg::SW_RESET_CYCLES;
        s_d.restart  = 1'b1;
        s_d.isolate  = wr_cu || wr_fi ? reg_wdata[ccr_pkg::BIT_ISOLATE] : s_q.isolate;
      end else if (s_q.sw_reset) begin
        if (s_q.rst_cnt == 4'h1) begin
          s_d.sw_reset = 1'b0;
        end
        s_d.rst_cnt = s_q.rst_cnt - 4'h1;
      end else if (s_q.restart) begin
        // Restart fires once the reset is done, then the bit clears
        s_d.restart = 1'b0;
        s_d.autoneg_strap_config_restart_pulse = 1'b1;
      end
    end
    eff = s_d.act;
    if (eff.autoneg_strap_config_en) begin
      s_d.adv = '{adv_1000_fd: 1'b0, adv_1000_hd: 1'b0, use_adv_regs: 1'b1, autoneg_strap_config_run: 1'b1};
    end else if (eff.speed == ccr_pkg::SPEED_1000) begin
      s_d.adv = '{adv_1000_fd: eff.duplex, adv_1000_hd: !eff.duplex, use_adv_regs: 1'b0, autoneg_strap_config_run: 1'b1};
    end else begin
      s_d.adv = '{adv_1000_fd: 1'b0, adv_1000_hd: 1'b0, use_adv_regs: 1'b0, autoneg_strap_config_run: 1'b0};
    end
    s_d.mac_off    = s_d.pwr_down && !misc_s2_q[1];
    s_d.refclk_off = s_d.pwr_down && misc_s2_q[0];
    s_d.mac_oe     = !s_d.isolate && !s_d.mac_off;
    // Isolated MAC inputs never reach the collision echo
    s_d.col = s_q.col_test && s_q.tx_en_s2 && !s_q.isolate;
    s_d.rdata = 16'h0000;
    if (reg_rd && reg_addr == ccr_pkg::REG_COPPER_CONTROL) begin
      s_d.rdata = ctrl_view(s_q, 1'b0);
    end else if (reg_rd && reg_addr == ccr_pkg::REG_FIBER_CONTROL) begin
      s_d.rdata = ctrl_view(s_q, 1'b1);
    end else if (reg_rd && reg_addr == ccr_pkg::REG_STRAP_STATUS) begin
      s_d.rdata = {s_q.act.autoneg_strap_config_en, s_q.act.duplex, s_q.act.speed, 4'h0, mode_s2_q, straps_s2_q};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.rsvd <= ccr_pkg::RSVD_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata                  = s_q.rdata;
  assign mac_col                    = s_q.col;
  assign mac_out_en                 = s_q.mac_oe;
  assign mac_if_off                 = s_q.mac_off;
  assign reference_clock_output_off = s_q.refclk_off;
  assign phy_sw_reset               = s_q.sw_reset;
  assign autoneg_strap_config_restart               = s_q.autoneg_strap_config_restart_pulse;
  assign oper_mode                  = s_q.act;
  assign adv_ctrl                   = s_q.adv;
endmodule

// >>> bench/ccr_chk.sv
`timescale 1ns/1ps
module ccr_chk (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               mac_tx_en,
  input wire logic               mac_col,
  input wire logic               mac_out_en,
  input wire logic               mac_if_off,
  input wire logic               phy_sw_reset,
  input wire logic               autoneg_strap_config_restart,
  input wire ccr_pkg::ccr_mode_t oper_mode,
  input wire ccr_pkg::ccr_adv_t  adv_ctrl
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_swr_len: assert property ($rose(phy_sw_reset) |-> phy_sw_reset[*8] ##1 !phy_sw_reset)
    else $error("software reset length wrong");
  a_swr_restart: assert property ($fell(phy_sw_reset) |-> ##1 autoneg_strap_config_restart)
    else $error("no restart after software reset");
  a_restart_pulse: assert property (autoneg_strap_config_restart |=> !autoneg_strap_config_restart)
    else $error("restart pulse too long");
  // Straps land just after reset, so those two edges are exempt
  a_mode_hold: assert property (!$stable(oper_mode) |-> $rose(phy_sw_reset) || $past(rst) || $past(rst, 2))
    else $error("mode changed without trigger");
  a_adv_forced: assert property (!oper_mode.autoneg_strap_config_en && oper_mode.speed == ccr_pkg::SPEED_1000 && !phy_sw_reset
    && $stable(oper_mode) |-> adv_ctrl == {oper_mode.duplex, !oper_mode.duplex, 2'b01})
    else $error("forced gigabit advertisement wrong");
  a_adv_on: assert property (oper_mode.autoneg_strap_config_en && !phy_sw_reset && $stable(oper_mode)
    |-> adv_ctrl.use_adv_regs && adv_ctrl.autoneg_strap_config_run)
    else $error("autoneg advertisement off");
  a_mac_off: assert property (mac_if_off && $past(mac_if_off) |-> !mac_out_en)
    else $error("mac outputs driven while off");
  a_col_src: assert property (mac_col |-> $past(mac_tx_en, 3) || $past(mac_tx_en, 4))
    else $error("collision without transmit");
endmodule
bind ccr_copper_control ccr_chk u_chk (.core_clk, .rst, .mac_tx_en, .mac_col, .mac_out_en, .mac_if_off,
  .phy_sw_reset, .autoneg_strap_config_restart, .oper_mode, .adv_ctrl);

// >>> bench/ccr_mac_model.sv
`timescale 1ns/1ps
module ccr_mac_model (
  input wire logic  core_clk,
  input wire logic  burst,
  input wire logic  mac_col,
  output logic       mac_tx_en,
  output logic [7:0] col_cnt
);
  initial begin
    mac_tx_en = 1'b0;
    col_cnt = 8'h00;
  end
  // Counts every cycle of collision so the bench can compare totals
  always @(posedge core_clk) begin
    mac_tx_en <= burst;
    col_cnt <= col_cnt + {7'h00, mac_col};
  end
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, burst = 1'b0;
  logic keep_mac_if_on = 1'b1, refclk_pd_en = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [3:0] autoneg_strap_config = 4'hC, hardware_config_strap_mode = 4'h0;
  logic mac_tx_en, mac_col, mac_out_en, mac_if_off, reference_clock_output_off, phy_sw_reset, autoneg_strap_config_restart;
  logic [7:0] col_cnt, c0;
  ccr_pkg::ccr_mode_t oper_mode;
  ccr_pkg::ccr_adv_t adv_ctrl;
  int err_count = 0, samples_checked = 0, pulses = 0, p0;
  // Columns: write index, write data, read index, expected read data
  logic [15:0] rows [0:5][0:3] = '{'{16'h0000, 16'h11D5, 16'h0000, 16'h11D5},
    '{16'h0000, 16'h11D5, 16'h0001, 16'h0080}, '{16'h0001, 16'h0480, 16'h0000, 16'h15D5},
    '{16'h0001, 16'h0000, 16'h0000, 16'h1155}, '{16'h0002, 16'hFFFF, 16'h0000, 16'h1155},
    '{16'h0000, 16'h0155, 16'h0000, 16'h0155}};
  ccr_copper_control uut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .autoneg_strap_config, .hardware_config_strap_mode, .keep_mac_if_on, .refclk_pd_en, .mac_tx_en, .mac_col,
    .mac_out_en, .mac_if_off, .reference_clock_output_off, .phy_sw_reset, .autoneg_strap_config_restart, .oper_mode, .adv_ctrl);
  ccr_mac_model mac (.core_clk, .burst, .mac_col, .mac_tx_en, .col_cnt);
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (autoneg_strap_config_restart === 1'b1) pulses++;
  task automatic chk(input logic ok);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t value mismatch", $time);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata === e);
  endtask
  // A fixed six-cycle frame keeps the expected collision count exact
  task automatic frame(input logic [7:0] e);
    c0 = col_cnt;
    burst <= 1'b1;
    tick(6);
    burst <= 1'b0;
    tick(6);
    chk(col_cnt - c0 === e);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #40000;
    err_count++;
    end_sim;
  end
  initial begin
    tick(20);
    rst <= 1'b0;
    tick(6);
    chk(oper_mode === 4'b1110);
    chk(pulses === 1);
    rd(5'h00, 16'h1140);
    foreach (rows[i]) begin
      wr(rows[i][0][4:0], rows[i][1]);
      rd(rows[i][2][4:0], rows[i][3]);
      chk(oper_mode === 4'b1110);
    end
    wr(5'h00, 16'h01D5);
    frame(8'h06);
    wr(5'h00, 16'h05D5);
    tick(3);
    chk(mac_out_en === 1'b0);
    frame(8'h00);
    // Forced 100 with autoneg off must stop negotiating altogether
    wr(5'h00, 16'hA015);
    tick(14);
    chk(oper_mode === 4'b0001);
    chk(adv_ctrl === 4'b0000);
    rd(5'h00, 16'h2015);
    for (int d = 1; d >= 0; d--) begin
      p0 = pulses;
      wr(5'h00, 16'h8055 | (16'(d) << 8));
      tick(1);
      chk(phy_sw_reset === 1'b1);
      tick(13);
      chk(oper_mode === {1'b0, d[0], 2'b10});
      chk(adv_ctrl === {d[0], !d[0], 2'b01});
      chk(pulses === p0 + 1);
      rd(5'h00, 16'h0055 | (16'(d) << 8));
    end
    wr(5'h00, 16'h1855);
    tick(4);
    chk(mac_if_off === 1'b0);
    chk(reference_clock_output_off === 1'b0);
    keep_mac_if_on <= 1'b0;
    refclk_pd_en <= 1'b1;
    tick(4);
    chk(mac_if_off === 1'b1 && mac_out_en === 1'b0);
    chk(reference_clock_output_off === 1'b1);
    chk(oper_mode === 4'b0010);
    p0 = pulses;
    wr(5'h00, 16'h1055);
    tick(14);
    chk(oper_mode === 4'b1010 && pulses === p0 + 1);
    chk(adv_ctrl.use_adv_regs === 1'b1);
    p0 = pulses;
    wr(5'h00, 16'h1255);
    tick(3);
    chk(pulses === p0 + 1);
    rd(5'h00, 16'h1055);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(6);
    chk(oper_mode === 4'b1110);
    end_sim;
  end
endmodule
